// >>> logic/msc_consts.svh
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
// Register byte offsets
`define MSC_OFF_CTRL 4'h0
`define MSC_OFF_STATUS 4'h4
`define MSC_OFF_DELAY 4'h8
// Control register fields
`define MSC_CTRL_HALF 0
`define MSC_CTRL_RATE_LO 1
`define MSC_CTRL_RATE_HI 2
`define MSC_CTRL_ADC 3
`define MSC_CTRL_ID_LO 4
`define MSC_CTRL_ID_HI 10
`define MSC_CTRL_RST 11'h000
// Stream slots, zero based channel index
`define MSC_CH_MIDI 6'h37
`define MSC_CH_MIDI_HALF 6'h1B
`define MSC_CH_SER_END 6'h09
`define MSC_CH_ADC 6'h09
`define MSC_CH_UNIT0 6'h0A
`define MSC_CH_UNIT2 6'h0C
// Remote ids and serial rate codes
`define MSC_ID_ALL 7'h7F
`define MSC_BAUD_9600 8'h00
`define MSC_BAUD_19200 8'h04
`define MSC_BAUD_115200 8'h08
`define MSC_BAUD_38400 8'h0C
// Timing
`define MSC_CLK_HZ 250000000
`define MSC_DIV(b) ((`MSC_CLK_HZ) / (b))
// Stream delay per unit in samples, chain sizes per rate
`define MSC_PASS_SS 8'h03
`define MSC_PASS_DS 8'h06
`define MSC_PASS_QS 8'h0C
`define MSC_CHAIN_SS 8'h08
`define MSC_CHAIN_DS 8'h04
`define MSC_CHAIN_QS 8'h02
`endif

// >>> logic/msc_pkg.sv
package msc_pkg;
  typedef enum logic [1:0] {
    MSC_SRC_MIDI = 2'b00,
    MSC_SRC_MADI = 2'b01,
    MSC_SRC_OFF = 2'b10
  } msc_src_e;
  typedef enum logic [1:0] {
    MSC_ROLE_NORMAL = 2'b00,
    MSC_ROLE_MASTER = 2'b01,
    MSC_ROLE_SLAVE = 2'b10
  } msc_role_e;
  typedef enum logic [1:0] {
    MSC_RATE_SINGLE = 2'b00,
    MSC_RATE_DOUBLE = 2'b01,
    MSC_RATE_QUAD = 2'b10
  } msc_rate_e;
  typedef enum logic [1:0] {
    MSC_OP_LOCK = 2'b00,
    MSC_OP_UNLOCK = 2'b01,
    MSC_OP_BAUD = 2'b10,
    MSC_OP_STATUS = 2'b11
  } msc_op_e;
endpackage : msc_pkg

// >>> logic/msc_side_channel.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "msc_consts.svh"
// What this block does
// [RL1] Unless the source is MADI, MIDI input rides the user bit of channel 56, or 28 in half frame.
// [RL2] MIDI user bit from the received stream drives the MIDI output.
// [RL3] MIDI insertion and extraction ignore the audio routing setup.
// [RL4] With MADI control source, received MIDI user bit is forwarded out.
// [RL5] Each source button press steps MIDI, MADI, off, and round again.
// [RL6] With the source off every remote command is ignored.
// [RL7] The source also picks where status replies go.
// [RL8] In MADI mode commands reach controller, MIDI out and MADI out.
// [RL9] Commands need our id or the wildcard id.
// [RL10] Remote lock disables all panel keys except the source key.
// [RL11] Selecting source off clears the lock.
// [RL12] Serial data rides the user bits of channels 1 to 9.
// [RL13] Serial rates 9600, 19200, 38400 and 115200 are supported.
// [RL14] Rate codes 00, 04, 08, 0C pick 9600, 19200, 115200, 38400.
// [RL15] The serial rate is kept in nonvolatile storage across restarts.
// [RL16] Normal and master: serial in goes out, serial out comes from input.
// [RL17] Slave: serial input ignored, received serial bits copied out.
// [RL18] Stream pass costs 3, 6 or 12 samples by rate.
// [RL19] Downstream units configure and delay their AES I/O to align.
// [RL20] Delays are sized for a full chain of eight, four or two units by rate.
// [RL21] Compensation adds 21, 18 or 12 samples to the round trip.
// [RL22] Integrator chains at most four units double, two quad rate.
// [RL23] User bits of channels without side data are sent as zero.
module msc_side_channel #(
  parameter int P_DIV_9600 = `MSC_DIV(9600),
  parameter int P_DIV_19200 = `MSC_DIV(19200),
  parameter int P_DIV_38400 = `MSC_DIV(38400),
  parameter int P_DIV_115200 = `MSC_DIV(115200)
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Received stream, one user bit per channel slot
  input wire logic i_rx_valid,
  input wire logic [5:0] i_rx_chan,
  input wire logic i_rx_user,
  // Transmitted stream
  input wire logic i_tx_req,
  input wire logic [5:0] i_tx_chan,
  output logic o_tx_valid,
  output logic o_tx_user,
  // MIDI and serial pins
  input wire logic i_midi_in,
  output logic o_midi_out,
  input wire logic i_ser_rx,
  output logic o_ser_tx,
  output logic o_baud_tick,
  // Panel
  input wire logic i_src_btn,
  input wire logic [7:0] i_panel_btn,
  output logic [7:0] o_panel_btn,
  // Decoded remote commands
  input wire logic i_cmd_valid,
  input wire msc_pkg::msc_src_e i_cmd_src,
  input wire logic [6:0] i_cmd_id,
  input wire msc_pkg::msc_op_e i_cmd_op,
  input wire logic [7:0] i_cmd_arg,
  output logic o_cmd_accept,
  output logic o_reply_midi,
  output logic o_reply_madi,
  // Nonvolatile rate store
  input wire logic [7:0] i_nv_baud,
  output logic o_nv_wr,
  output logic [7:0] o_nv_baud,
  // Alignment
  output logic [7:0] o_pass_delay,
  output logic [7:0] o_aes_delay
);
  import msc_pkg::*;
  logic [1:0] rst_q, midi_s, ser_s, btn_s, init_cnt;
  logic [15:0] pan_s, nv_s;
  logic [10:0] ctrl_reg;
  logic [7:0] baud_reg;
  logic [16:0] div_cnt;
  logic [8:0] ser_rx_bits;
  logic [2:0] unit_rx, unit_idx;
  logic [6:0] dev_id;
  logic rst_n, btn_d, lock_reg, midi_rx_bit, ser_last, adc_rx;
  logic btn_rise, half, cmd_ok, tx_bit;
  msc_src_e src_reg;
  msc_role_e role;
  msc_rate_e rate;
  function automatic logic [5:0] midi_chan(input logic h);
    midi_chan = h ? `MSC_CH_MIDI_HALF : `MSC_CH_MIDI;
  endfunction : midi_chan
  function automatic logic baud_ok(input logic [7:0] c);
    baud_ok = (c == `MSC_BAUD_9600) || (c == `MSC_BAUD_19200) ||
              (c == `MSC_BAUD_38400) || (c == `MSC_BAUD_115200);
  endfunction : baud_ok
  function automatic logic [16:0] baud_div(input logic [7:0] c);
    unique case (c)
      `MSC_BAUD_19200: baud_div = 17'(P_DIV_19200); // RL14
      `MSC_BAUD_38400: baud_div = 17'(P_DIV_38400); // RL14
      `MSC_BAUD_115200: baud_div = 17'(P_DIV_115200); // RL14
      default: baud_div = 17'(P_DIV_9600); // RL14
    endcase
  endfunction : baud_div
  function automatic logic [7:0] pass_dly(input msc_rate_e r);
    unique case (r)
      MSC_RATE_DOUBLE: pass_dly = `MSC_PASS_DS;
      MSC_RATE_QUAD: pass_dly = `MSC_PASS_QS;
      default: pass_dly = `MSC_PASS_SS;
    endcase
  endfunction : pass_dly
  // Unit k waits for the units still downstream of it in a full chain
  function automatic logic [7:0] aes_dly(input msc_rate_e r,
                                         input logic [2:0] k);
    logic [7:0] n;
    n = `MSC_CHAIN_SS;
    unique case (r)
      MSC_RATE_DOUBLE: n = `MSC_CHAIN_DS;
      MSC_RATE_QUAD: n = `MSC_CHAIN_QS;
      default: n = `MSC_CHAIN_SS;
    endcase
    if ({5'h00, k} >= n) begin
      aes_dly = 8'h00;
    end else begin
      aes_dly = 8'((n - 8'h01 - {5'h00, k}) * pass_dly(r));
    end
  endfunction : aes_dly
  assign half = ctrl_reg[`MSC_CTRL_HALF];
  assign rate = msc_rate_e'(ctrl_reg[`MSC_CTRL_RATE_HI:`MSC_CTRL_RATE_LO]);
  assign dev_id = ctrl_reg[`MSC_CTRL_ID_HI:`MSC_CTRL_ID_LO];
  assign btn_rise = btn_s[1] & ~btn_d;
  assign role = ctrl_reg[`MSC_CTRL_ADC] ? MSC_ROLE_MASTER :
                adc_rx ? MSC_ROLE_SLAVE : MSC_ROLE_NORMAL; // RL19
  assign unit_idx = (role == MSC_ROLE_SLAVE) ? 3'(unit_rx + 3'h1) : 3'h0;
  // Source off is excluded by its own term, so nothing is accepted then
  assign cmd_ok = i_cmd_valid && (i_cmd_src == src_reg) &&
                  (src_reg != MSC_SRC_OFF) &&
                  ((i_cmd_id == dev_id) ||
                   (i_cmd_id == `MSC_ID_ALL)); // RL6 RL9 RL8
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      midi_s <= 2'b11;
      ser_s <= 2'b11;
      btn_s <= 2'b00;
      pan_s <= 16'h0000;
      nv_s <= 16'h0000;
      btn_d <= 1'b0;
    end else begin
      midi_s <= {midi_s[0], i_midi_in};
      ser_s <= {ser_s[0], i_ser_rx};
      btn_s <= {btn_s[0], i_src_btn};
      pan_s <= {pan_s[7:0], i_panel_btn};
      nv_s <= {nv_s[7:0], i_nv_baud};
      btn_d <= btn_s[1];
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `MSC_CTRL_RST;
    end else if (i_wr && i_addr == `MSC_OFF_CTRL) begin
      ctrl_reg <= i_wdata[10:0];
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        `MSC_OFF_CTRL: o_rdata <= {21'h000000, ctrl_reg};
        `MSC_OFF_STATUS: o_rdata <= {14'h0000, baud_reg, 1'b0, unit_idx,
                                      role, lock_reg, 1'b0, src_reg};
        `MSC_OFF_DELAY: o_rdata <= {16'h0000, o_pass_delay, o_aes_delay};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_reg <= MSC_SRC_MIDI;
    end else if (btn_rise) begin
      unique case (src_reg)
        MSC_SRC_MIDI: src_reg <= MSC_SRC_MADI; // RL5
        MSC_SRC_MADI: src_reg <= MSC_SRC_OFF; // RL5
        default: src_reg <= MSC_SRC_MIDI; // RL5
      endcase
    end
  end
  // Lock; source off wins so local control is always recoverable
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (src_reg == MSC_SRC_OFF) begin
      lock_reg <= 1'b0; // RL11
    end else if (cmd_ok && i_cmd_op == MSC_OP_LOCK) begin
      lock_reg <= 1'b1; // RL10
    end else if (cmd_ok && i_cmd_op == MSC_OP_UNLOCK) begin
      lock_reg <= 1'b0;
    end
  end
  // Source key bypasses the lock by not passing through here
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_panel_btn <= 8'h00;
    end else begin
      o_panel_btn <= lock_reg ? 8'h00 : pan_s[15:8]; // RL10
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmd_accept <= 1'b0;
      o_reply_midi <= 1'b0;
      o_reply_madi <= 1'b0;
    end else begin
      o_cmd_accept <= cmd_ok; // RL6 RL9
      o_reply_midi <= (src_reg == MSC_SRC_MIDI); // RL7
      o_reply_madi <= (src_reg == MSC_SRC_MADI); // RL7 RL8
    end
  end
  // Serial rate: restored once the store's pins have settled
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt <= 2'h0;
      baud_reg <= `MSC_BAUD_9600;
      o_nv_wr <= 1'b0;
      o_nv_baud <= `MSC_BAUD_9600;
    end else begin
      o_nv_wr <= 1'b0;
      if (init_cnt != 2'h3) begin
        init_cnt <= 2'(init_cnt + 2'h1);
        if (init_cnt == 2'h2 && baud_ok(nv_s[15:8])) begin
          baud_reg <= nv_s[15:8]; // RL15
          o_nv_baud <= nv_s[15:8];
        end
      end else if (cmd_ok && i_cmd_op == MSC_OP_BAUD &&
                   baud_ok(i_cmd_arg)) begin
        baud_reg <= i_cmd_arg; // RL14
        o_nv_baud <= i_cmd_arg; // RL15
        o_nv_wr <= 1'b1; // RL15
      end
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 17'h00000;
      o_baud_tick <= 1'b0;
    end else if (div_cnt >= 17'(baud_div(baud_reg) - 1)) begin
      div_cnt <= 17'h00000;
      o_baud_tick <= 1'b1; // RL13
    end else begin
      div_cnt <= 17'(div_cnt + 17'h00001);
      o_baud_tick <= 1'b0;
    end
  end
  // Receive side slot capture; routing matrix never enters here
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      midi_rx_bit <= 1'b1;
      ser_rx_bits <= 9'h1FF;
      ser_last <= 1'b1;
      adc_rx <= 1'b0;
      unit_rx <= 3'h0;
    end else if (i_rx_valid) begin
      if (i_rx_chan == midi_chan(half)) begin
        midi_rx_bit <= i_rx_user; // RL2 RL3
      end
      if (i_rx_chan < `MSC_CH_SER_END) begin
        ser_rx_bits[i_rx_chan[3:0]] <= i_rx_user; // RL12
        ser_last <= i_rx_user;
      end
      if (i_rx_chan == `MSC_CH_ADC) begin
        adc_rx <= i_rx_user; // RL19
      end
      if (i_rx_chan >= `MSC_CH_UNIT0 && i_rx_chan <= `MSC_CH_UNIT2) begin
        unit_rx[2'(i_rx_chan - `MSC_CH_UNIT0)] <= i_rx_user;
      end
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_midi_out <= 1'b1;
      o_ser_tx <= 1'b1;
    end else begin
      o_midi_out <= midi_rx_bit; // RL2 RL8
      o_ser_tx <= ser_last; // RL16
    end
  end
  always_comb begin
    tx_bit = 1'b0; // RL23
    if (i_tx_chan == midi_chan(half)) begin
      tx_bit = (src_reg == MSC_SRC_MADI) ? midi_rx_bit // RL4 RL8
                                         : midi_s[1]; // RL1 RL3
    end else if (i_tx_chan < `MSC_CH_SER_END) begin
      tx_bit = (role == MSC_ROLE_SLAVE) ? ser_rx_bits[i_tx_chan[3:0]] // RL17
                                        : ser_s[1]; // RL12 RL16
    end else if (i_tx_chan == `MSC_CH_ADC) begin
      tx_bit = (role != MSC_ROLE_NORMAL); // RL19
    end else if (i_tx_chan >= `MSC_CH_UNIT0 &&
                 i_tx_chan <= `MSC_CH_UNIT2) begin
      tx_bit = (role != MSC_ROLE_NORMAL) &&
               unit_idx[2'(i_tx_chan - `MSC_CH_UNIT0)];
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_user <= 1'b0;
    end else begin
      o_tx_valid <= i_tx_req;
      o_tx_user <= i_tx_req ? tx_bit : 1'b0;
    end
  end
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_pass_delay <= `MSC_PASS_SS;
      o_aes_delay <= 8'h00;
    end else begin
      o_pass_delay <= pass_dly(rate); // RL18
      o_aes_delay <= (role == MSC_ROLE_NORMAL) ? 8'h00
                     : aes_dly(rate, unit_idx); // RL19 RL20 RL21
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  sequence s_midi_slot;
    i_tx_req && i_tx_chan == midi_chan(half);
  endsequence
  sequence s_ser_slot;
    i_tx_req && i_tx_chan < `MSC_CH_SER_END;
  endsequence
  sequence s_midi_rx;
    i_rx_valid && i_rx_chan == midi_chan(half) ##1 !i_rx_valid;
  endsequence

  AST_MIDI_IN: assert property ( // RL1
    s_midi_slot and (src_reg != MSC_SRC_MADI) |=>
      o_tx_user == $past(midi_s[1]))
    else $error("MIDI slot lost input");
  AST_MIDI_OUT: assert property ( // RL2
    s_midi_rx |=> o_midi_out == $past(i_rx_user, 2))
    else $error("MIDI output not from stream");
  AST_MADI_FWD: assert property ( // RL4
    s_midi_slot and (src_reg == MSC_SRC_MADI) |=>
      o_tx_user == $past(midi_rx_bit))
    else $error("MIDI not forwarded");
  AST_SRC_STEP: assert property ( // RL5
    btn_rise && src_reg == MSC_SRC_OFF |=> src_reg == MSC_SRC_MIDI)
    else $error("Selector did not wrap");
  AST_OFF_IGNORE: assert property ( // RL6
    src_reg == MSC_SRC_OFF |=> !o_cmd_accept)
    else $error("Command taken while off");
  AST_REPLY: assert property ( // RL7
    src_reg == MSC_SRC_MIDI [*3] |-> o_reply_midi && !o_reply_madi)
    else $error("Reply not on MIDI");
  AST_ID: assert property ( // RL9
    i_cmd_valid && i_cmd_id != dev_id && i_cmd_id != `MSC_ID_ALL
      |=> !o_cmd_accept)
    else $error("Foreign id accepted");
  AST_LOCK: assert property ( // RL10
    lock_reg |=> o_panel_btn == 8'h00)
    else $error("Panel live while locked");
  AST_UNLOCK: assert property ( // RL11
    src_reg == MSC_SRC_OFF |=> !lock_reg)
    else $error("Lock held with source off");
  AST_SER_IN: assert property ( // RL16
    s_ser_slot and (role != MSC_ROLE_SLAVE) |=>
      o_tx_user == $past(ser_s[1]))
    else $error("Serial input not sent");
  AST_SLAVE: assert property ( // RL17
    s_ser_slot and (role == MSC_ROLE_SLAVE) |=>
      o_tx_user == $past(ser_rx_bits[i_tx_chan[3:0]]))
    else $error("Slave did not copy");
  AST_PASS: assert property ( // RL18
    rate == MSC_RATE_QUAD [*2] |-> o_pass_delay == 8'h0C)
    else $error("Wrong pass delay");
  AST_MASTER_DLY: assert property ( // RL21
    role == MSC_ROLE_MASTER && rate == MSC_RATE_SINGLE [*2]
      |-> o_aes_delay == 8'h15)
    else $error("Master delay not 21");
  AST_ZERO: assert property ( // RL23
    i_tx_req && i_tx_chan > `MSC_CH_UNIT2 &&
      i_tx_chan != midi_chan(half) |=> !o_tx_user)
    else $error("Unused slot not zero");
endmodule : msc_side_channel

// >>> testbench/msc_peer.sv
`timescale 1ns/10ps
module msc_peer (
  // Clock
  input wire logic i_mclk,
  // Slots sent into the block
  output logic o_rx_valid,
  output logic [5:0] o_rx_chan,
  output logic o_rx_user,
  // Slots asked of the block
  output logic o_tx_req,
  output logic [5:0] o_tx_chan,
  input wire logic i_tx_valid,
  input wire logic i_tx_user
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_chan = 6'h00;
    o_rx_user = 1'b0;
    o_tx_req = 1'b0;
    o_tx_chan = 6'h00;
  end
  // Between slots the lines carry the inverse, so stale bits never match
  task automatic send(input logic [5:0] ch, input logic b);
    @(posedge i_mclk);
    o_rx_valid <= 1'b1;
    o_rx_chan <= ch;
    o_rx_user <= b;
    @(posedge i_mclk);
    o_rx_valid <= 1'b0;
    o_rx_chan <= ~ch;
    o_rx_user <= ~b;
  endtask : send
  task automatic poll(input logic [5:0] ch, output logic v, output logic b);
    @(posedge i_mclk);
    o_tx_req <= 1'b1;
    o_tx_chan <= ch;
    @(posedge i_mclk);
    o_tx_req <= 1'b0;
    o_tx_chan <= ~ch;
    #1;
    v = i_tx_valid;
    b = i_tx_user;
  endtask : poll
endmodule : msc_peer

// >>> testbench/test_msc_side_channel.sv
`timescale 1ns/10ps
`include "msc_consts.svh"
module test_msc_side_channel;
  import msc_pkg::*;
  logic i_mclk, i_reset_n, i_wr, i_rd, i_rx_valid, i_rx_user, i_tx_req;
  logic o_tx_valid, o_tx_user, i_midi_in, o_midi_out, i_ser_rx, o_ser_tx;
  logic o_baud_tick, i_src_btn, i_cmd_valid, o_cmd_accept, o_nv_wr;
  logic o_reply_midi, o_reply_madi, v, b, a;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [5:0] i_rx_chan, i_tx_chan;
  logic [7:0] i_panel_btn, o_panel_btn, i_cmd_arg, i_nv_baud, o_nv_baud;
  logic [7:0] o_pass_delay, o_aes_delay;
  logic [6:0] i_cmd_id;
  msc_src_e i_cmd_src;
  msc_op_e i_cmd_op;
  int errors, tests_run, n;
  msc_side_channel #(.P_DIV_9600(8), .P_DIV_19200(6), .P_DIV_38400(4),
    .P_DIV_115200(2)) uut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rx_valid(i_rx_valid), .i_rx_chan(i_rx_chan), .i_rx_user(i_rx_user),
    .i_tx_req(i_tx_req), .i_tx_chan(i_tx_chan), .o_tx_valid(o_tx_valid),
    .o_tx_user(o_tx_user), .i_midi_in(i_midi_in), .o_midi_out(o_midi_out),
    .i_ser_rx(i_ser_rx), .o_ser_tx(o_ser_tx), .o_baud_tick(o_baud_tick),
    .i_src_btn(i_src_btn), .i_panel_btn(i_panel_btn),
    .o_panel_btn(o_panel_btn), .i_cmd_valid(i_cmd_valid),
    .i_cmd_src(i_cmd_src), .i_cmd_id(i_cmd_id), .i_cmd_op(i_cmd_op),
    .i_cmd_arg(i_cmd_arg), .o_cmd_accept(o_cmd_accept),
    .o_reply_midi(o_reply_midi), .o_reply_madi(o_reply_madi),
    .i_nv_baud(i_nv_baud), .o_nv_wr(o_nv_wr), .o_nv_baud(o_nv_baud),
    .o_pass_delay(o_pass_delay), .o_aes_delay(o_aes_delay));
  msc_peer peer (.i_mclk(i_mclk), .o_rx_valid(i_rx_valid),
    .o_rx_chan(i_rx_chan), .o_rx_user(i_rx_user), .o_tx_req(i_tx_req),
    .o_tx_chan(i_tx_chan), .i_tx_valid(o_tx_valid), .i_tx_user(o_tx_user));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic wt(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask : wt
  task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= wd;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [31:0] rv);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
  endtask : rd
  task automatic cmd(input msc_src_e s, input logic [6:0] id,
                     input msc_op_e op, input logic [7:0] arg);
    @(posedge i_mclk);
    i_cmd_valid <= 1'b1;
    i_cmd_src <= s;
    i_cmd_id <= id;
    i_cmd_op <= op;
    i_cmd_arg <= arg;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    #1;
    a = o_cmd_accept;
  endtask : cmd
  // Key is a slow asynchronous level, so hold it past the synchronizer
  task automatic press;
    @(posedge i_mclk) i_src_btn <= 1'b1;
    wt(6);
    @(posedge i_mclk) i_src_btn <= 1'b0;
    wt(6);
  endtask : press
  task automatic period(output int p);
    int k;
    k = 0;
    while (o_baud_tick !== 1'b1 && k < 100) begin
      wt(1);
      k++;
    end
    wt(1);
    p = 1;
    while (o_baud_tick !== 1'b1 && p < 100) begin
      wt(1);
      p++;
    end
  endtask : period
  task automatic t_midi;
    check("midi_out_idle", o_midi_out, 1);
  endtask : t_midi
  task automatic t_stream;
    @(posedge i_mclk) i_midi_in <= 1'b0;
    wt(6);
    peer.poll(`MSC_CH_MIDI, v, b);
    check("tx_valid", v, 1);
    check("midi_slot", b, 0);
    @(posedge i_mclk) i_midi_in <= 1'b1;
    wt(6);
    peer.poll(`MSC_CH_MIDI, v, b);
    check("midi_slot", b, 1);
    peer.poll(6'h14, v, b);
    check("empty_slot", b, 0);
    wr(`MSC_OFF_CTRL, 32'h1);
    wt(2);
    peer.poll(`MSC_CH_MIDI_HALF, v, b);
    check("half_slot", b, 1);
    peer.poll(`MSC_CH_MIDI, v, b);
    check("full_slot_off", b, 0);
    wr(`MSC_OFF_CTRL, 32'h50);
    peer.send(`MSC_CH_MIDI, 1'b0);
    wt(3);
    check("midi_out", o_midi_out, 0);
    peer.send(`MSC_CH_MIDI, 1'b1);
    wt(3);
    check("midi_out", o_midi_out, 1);
    peer.poll(6'h00, v, b);
    check("ser_slot_idle", b, 1);
    @(posedge i_mclk) i_ser_rx <= 1'b0;
    wt(6);
    for (int c = 0; c < 9; c++) begin
      peer.poll(6'(c), v, b);
      check("ser_slot", b, 0);
    end
    peer.poll(`MSC_CH_SER_END, v, b);
    check("adc_flag", b, 0);
    peer.send(6'h03, 1'b0);
    wt(3);
    check("ser_tx", o_ser_tx, 0);
    peer.send(6'h08, 1'b1);
    wt(3);
    check("ser_tx", o_ser_tx, 1);
  endtask : t_stream
  task automatic t_cmds;
    cmd(MSC_SRC_MIDI, 7'h05, MSC_OP_STATUS, 8'h00);
    check("accept_id", a, 1);
    cmd(MSC_SRC_MIDI, 7'h06, MSC_OP_LOCK, 8'h00);
    check("reject_id", a, 0);
    cmd(MSC_SRC_MIDI, `MSC_ID_ALL, MSC_OP_LOCK, 8'h00);
    check("accept_all", a, 1);
    wt(2);
    check("locked", o_panel_btn, 0);
    press();
    rd(`MSC_OFF_STATUS, d);
    check("src_madi", d[1:0], MSC_SRC_MADI);
    check("reply_madi", o_reply_madi, 1);
    cmd(MSC_SRC_MIDI, 7'h05, MSC_OP_UNLOCK, 8'h00);
    check("midi_in_unused", a, 0);
    peer.send(`MSC_CH_MIDI, 1'b0);
    wt(3);
    peer.poll(`MSC_CH_MIDI, v, b);
    check("madi_forward", b, 0);
    check("madi_to_midi", o_midi_out, 0);
    press();
    rd(`MSC_OFF_STATUS, d);
    check("src_off", d[1:0], MSC_SRC_OFF);
    check("unlocked", o_panel_btn, 8'hA5);
    cmd(MSC_SRC_MADI, `MSC_ID_ALL, MSC_OP_LOCK, 8'h00);
    check("off_ignores", a, 0);
    cmd(MSC_SRC_MIDI, `MSC_ID_ALL, MSC_OP_LOCK, 8'h00);
    check("off_ignores", a, 0);
    wt(2);
    check("off_no_lock", o_panel_btn, 8'hA5);
    press();
    rd(`MSC_OFF_STATUS, d);
    check("src_midi", d[1:0], MSC_SRC_MIDI);
    check("reply_midi", o_reply_midi, 1);
    check("reply_midi_only", o_reply_madi, 0);
    rd(4'hC, d);
    check("unmapped", d, 0);
  endtask : t_cmds
  task automatic t_baud;
    logic [7:0] code [4] = '{`MSC_BAUD_9600, `MSC_BAUD_19200,
                             `MSC_BAUD_115200, `MSC_BAUD_38400};
    int dv [4] = '{8, 6, 2, 4};
    for (int i = 0; i < 4; i++) begin
      cmd(MSC_SRC_MIDI, 7'h05, MSC_OP_BAUD, code[i]);
      check("nv_wr", o_nv_wr, 1);
      check("nv_baud", o_nv_baud, code[i]);
      period(n);
      period(n);
      check("tick_period", n, dv[i]);
    end
    cmd(MSC_SRC_MIDI, 7'h05, MSC_OP_BAUD, 8'h03);
    check("bad_code_nv", o_nv_wr, 0);
    period(n);
    period(n);
    check("bad_code_keep", n, 4);
  endtask : t_baud
  task automatic t_align;
    logic [7:0] ps [3] = '{`MSC_PASS_SS, `MSC_PASS_DS, `MSC_PASS_QS};
    logic [7:0] ch [3] = '{`MSC_CHAIN_SS, `MSC_CHAIN_DS, `MSC_CHAIN_QS};
    // Master at each rate; chains stay within their size limits
    for (int r = 0; r < 3; r++) begin
      wr(`MSC_OFF_CTRL, 32'h58 | (r << 1));
      wt(3);
      rd(`MSC_OFF_DELAY, d);
      check("pass", d[15:8], ps[r]);
      check("aes", d[7:0], (ch[r] - 8'h01) * ps[r]);
      check("aes_port", o_aes_delay, (ch[r] - 8'h01) * ps[r]);
      peer.poll(`MSC_CH_ADC, v, b);
      check("adc_flag", b, 1);
    end
    wr(`MSC_OFF_CTRL, 32'h50);
    peer.send(`MSC_CH_ADC, 1'b1);
    peer.send(`MSC_CH_UNIT0, 1'b0);
    peer.send(6'h0B, 1'b0);
    peer.send(`MSC_CH_UNIT2, 1'b0);
    wt(3);
    rd(`MSC_OFF_STATUS, d);
    check("role_slave", d[5:4], MSC_ROLE_SLAVE);
    check("slave_aes", o_aes_delay, 8'h12);
    peer.poll(`MSC_CH_UNIT0, v, b);
    check("unit_index", b, 1);
    @(posedge i_mclk) i_ser_rx <= 1'b0;
    wt(6);
    peer.send(6'h04, 1'b1);
    wt(3);
    peer.poll(6'h04, v, b);
    check("slave_ser", b, 1);
  endtask : t_align
  task automatic t_restart;
    @(posedge i_mclk) i_nv_baud <= `MSC_BAUD_115200;
    @(posedge i_mclk) i_reset_n <= 1'b0;
    wt(20);
    @(posedge i_mclk) i_reset_n <= 1'b1;
    wt(10);
    check("pass_reset", o_pass_delay, `MSC_PASS_SS);
    period(n);
    period(n);
    check("restored_rate", n, 2);
  endtask : t_restart
  initial begin
    #240000;
    errors++;
    close_out();
  end
  initial begin
    {i_wr, i_rd, i_src_btn, i_cmd_valid, i_reset_n} = '0;
    {i_midi_in, i_ser_rx} = 2'b11;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    i_panel_btn = 8'hA5;
    i_cmd_src = MSC_SRC_MIDI;
    i_cmd_op = MSC_OP_STATUS;
    i_cmd_id = 7'h00;
    i_cmd_arg = 8'h00;
    i_nv_baud = `MSC_BAUD_9600;
    wt(20);
    @(posedge i_mclk) i_reset_n <= 1'b1;
    wt(10);
    check("ser_idle", o_ser_tx, 1);
    check("panel_free", o_panel_btn, 8'hA5);
    check("aes_reset", o_aes_delay, 0);
    t_midi();
    t_stream();
    t_cmds();
    t_baud();
    t_align();
    t_restart();
    close_out();
  end
endmodule : test_msc_side_channel
